// ---- core/pbw_pkg.sv ----
// package for the push-button wiper counter: timing counts, carriers
// assumes a 100 MHz clk; nonvolatile store and supply monitor sit outside
// Function
// R01 - debounced low on up button steps wiper one tap higher
// R02 - debounced low on down button steps wiper one tap lower
// R03 - wiper position held in a 5-bit up/down counter
// R04 - counter decoded one-hot, exactly one of 32 tap switches on
// R05 - low pulses shorter than the 40 ms debounce never move the wiper
// R06 - short press gives one step, held press keeps stepping
// R07 - first second of a hold repeats at the slow scan rate
// R08 - hold beyond 1 second switches to the fast scan rate
// R09 - release stops stepping at once, back to standby, scan mode cleared
// R10 - counter saturates at both ends, no wrap-around
// R11 - store-mode low saves counter to memory on supply loss
// R12 - at power-up stored value is recalled into the counter
// R13 - store-mode input debounced; low enables save on power loss
// R14 - with auto save off, debounced rising store-mode starts manual save
// R15 - store-mode high at power-up then low blocks steps until high again
// R16 - outside party requests manual save by pulsing store-mode low then high
// R17 - slow scan: about 250 ms from debounce end to each change
// R18 - fast scan: about 50 ms between successive changes
// R19 - recalled position settled within 500 us of power-up
// R20 - both step buttons low holds the counter, no step
// R21 - all timing derived from an internal free-running time base; the recall timeout counts clk cycles instead of ticks
package pbw_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int DEBOUNCE_MS = 40;
    localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_US;
    localparam int SLOW_MS = 250;
    localparam int SLOW_TICKS = SLOW_MS * 1000 / TICK_US;
    localparam int FAST_MS = 50;
    localparam int FAST_TICKS = FAST_MS * 1000 / TICK_US;
    localparam int LONG_MS = 1000;
    localparam int LONG_TICKS = LONG_MS * 1000 / TICK_US;
    localparam int RECALL_US = 500;
    localparam int RECALL_CYC = CLK_HZ / 1_000_000 * RECALL_US;
    localparam logic [4:0] WIPER_RST = 5'h00;

    typedef enum logic [1:0] {
        PBW_RECALL = 2'b00,
        PBW_IDLE = 2'b01,
        PBW_SLOW = 2'b11,
        PBW_FAST = 2'b10
    } pbw_state_t;

    typedef struct packed {
        logic save_req;
        logic [4:0] save_data;
    } pbw_nv_req_t;
endpackage

// ---- core/pbw_top.sv ----
// push-button wiper counter, step logic, tap decode and store control
// assumes button pins asynchronous, pulled high off chip; nv memory answers
// recall_valid once after reset and accepts one-cycle save requests
`timescale 1ns/1ps
module pbw_top #(
    parameter int DEBOUNCE_TICKS = pbw_pkg::DEBOUNCE_TICKS,
    parameter int SLOW_TICKS = pbw_pkg::SLOW_TICKS,
    parameter int FAST_TICKS = pbw_pkg::FAST_TICKS,
    parameter int LONG_TICKS = pbw_pkg::LONG_TICKS,
    parameter int TICK_CYC = pbw_pkg::TICK_CYC,
    parameter int RECALL_CYC = pbw_pkg::RECALL_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic step_up_button_n,
    input wire logic step_down_button_n,
    input wire logic store_mode_select_n,
    input wire logic supply_loss,
    input wire logic recall_valid,
    input wire logic [4:0] recall_data,
    output logic [31:0] tap_select,
    output logic [4:0] wiper_position,
    output pbw_pkg::pbw_nv_req_t nv_req,
    output logic ready
);
    // ==================================================================
    // synchronisers
    logic [2:0] meta_q, sync_q;
    always_ff @(posedge clk) begin
        meta_q <= {store_mode_select_n, step_down_button_n, step_up_button_n};
        sync_q <= meta_q;
    end

    // ==================================================================
    // time base
    logic [15:0] pre_q, pre_d;
    logic tick;
    // R21 free-running tick
    always_comb begin
        tick = (pre_q == 16'(TICK_CYC - 1));
        pre_d = tick ? 16'h0000 : pre_q + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (srst) pre_q <= 16'h0000;
        else pre_q <= pre_d;
    end

    // ==================================================================
    // debouncers; filtered level only changes after a stable interval
    logic [2:0] deb_q, deb_d;
    logic [2:0][19:0] dcnt_q, dcnt_d;
    // R05 R13 debounce both step buttons and store-mode
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            deb_d[i] = deb_q[i];
            dcnt_d[i] = dcnt_q[i];
            if (sync_q[i] == deb_q[i]) dcnt_d[i] = 20'h0_0000;
            else if (tick) begin
                if (dcnt_q[i] == 20'(DEBOUNCE_TICKS - 1)) begin
                    deb_d[i] = sync_q[i];
                    dcnt_d[i] = 20'h0_0000;
                end else dcnt_d[i] = dcnt_q[i] + 20'h0_0001;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            deb_q <= 3'b111;
            dcnt_q <= '0;
        end else begin
            deb_q <= deb_d;
            dcnt_q <= dcnt_d;
        end
    end
    logic up_act, dn_act, ase_hi;
    assign up_act = ~deb_q[0];
    assign dn_act = ~deb_q[1];
    assign ase_hi = deb_q[2];

    // ==================================================================
    // step engine
    pbw_pkg::pbw_state_t st_q, st_d;
    logic [4:0] pos_q, pos_d;
    logic [19:0] rate_q, rate_d;
    logic [19:0] hold_q, hold_d;
    logic [15:0] rc_q, rc_d;
    logic ase_pu_q, ase_pu_d, lock_q, lock_d, ase_prev_q;
    logic save_q, save_d, one_act, step;
    assign one_act = up_act ^ dn_act;
    always_comb begin
        st_d = st_q;
        pos_d = pos_q;
        rate_d = rate_q;
        hold_d = hold_q;
        rc_d = rc_q;
        ase_pu_d = ase_pu_q;
        lock_d = lock_q;
        save_d = 1'b0;
        step = 1'b0;
        case (st_q)
            pbw_pkg::PBW_RECALL: begin
                // R12 R19 load stored value, time out to default
                rc_d = rc_q + 16'h0001;
                if (recall_valid || rc_q == 16'(RECALL_CYC - 1)) begin
                    if (recall_valid) pos_d = recall_data;
                    ase_pu_d = sync_q[2];
                    st_d = pbw_pkg::PBW_IDLE;
                end
            end
            pbw_pkg::PBW_IDLE: begin
                // R01 R02 R06 R20 first step at debounce end
                if (one_act && !lock_q) begin
                    step = 1'b1;
                    rate_d = 20'h0_0000;
                    hold_d = 20'h0_0000;
                    st_d = pbw_pkg::PBW_SLOW;
                end
            end
            pbw_pkg::PBW_SLOW, pbw_pkg::PBW_FAST: begin
                if (!one_act || lock_q) begin
                    // R09 release back to standby
                    st_d = pbw_pkg::PBW_IDLE;
                end else if (tick) begin
                    rate_d = rate_q + 20'h0_0001;
                    if (hold_q != 20'(LONG_TICKS)) hold_d = hold_q + 20'h0_0001;
                    // R07 R17 slow repeat
                    if (st_q == pbw_pkg::PBW_SLOW && rate_q == 20'(SLOW_TICKS - 1)) begin
                        step = 1'b1;
                        rate_d = 20'h0_0000;
                    end
                    // R08 R18 fast repeat
                    if (st_q == pbw_pkg::PBW_FAST && rate_q == 20'(FAST_TICKS - 1)) begin
                        step = 1'b1;
                        rate_d = 20'h0_0000;
                    end
                    if (st_q == pbw_pkg::PBW_SLOW && hold_q == 20'(LONG_TICKS - 1)) begin
                        st_d = pbw_pkg::PBW_FAST;
                        rate_d = 20'h0_0000;
                    end
                end
            end
            default: st_d = pbw_pkg::PBW_RECALL;
        endcase
        // R03 R10 saturating counter
        if (step && up_act && pos_q != 5'h1F) pos_d = pos_q + 5'h01;
        if (step && dn_act && pos_q != 5'h00) pos_d = pos_q - 5'h01;
        if (st_q != pbw_pkg::PBW_RECALL) begin
            // R15 lockout while store-mode low after high power-up
            if (ase_pu_q && !ase_hi) lock_d = 1'b1;
            else if (ase_hi) lock_d = 1'b0;
            // R14 manual save on debounced rise
            if (ase_hi && !ase_prev_q) save_d = 1'b1;
            // R11 save on supply loss when auto save enabled
            if (!ase_hi && supply_loss) save_d = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= pbw_pkg::PBW_RECALL;
            pos_q <= pbw_pkg::WIPER_RST;
            rate_q <= 20'h0_0000;
            hold_q <= 20'h0_0000;
            rc_q <= 16'h0000;
            ase_pu_q <= 1'b0;
            lock_q <= 1'b0;
            save_q <= 1'b0;
            ase_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            pos_q <= pos_d;
            rate_q <= rate_d;
            hold_q <= hold_d;
            rc_q <= rc_d;
            ase_pu_q <= ase_pu_d;
            lock_q <= lock_d;
            save_q <= save_d;
            ase_prev_q <= ase_hi;
        end
    end

    // ==================================================================
    // outputs, all registered
    logic [31:0] tap_q;
    logic [4:0] nvd_q;
    logic rdy_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            tap_q <= 32'h0000_0000;
            nvd_q <= 5'h00;
            rdy_q <= 1'b0;
        end else begin
            // R04 one-hot decode
            tap_q <= 32'h0000_0001 << pos_d;
            nvd_q <= pos_q;
            rdy_q <= (st_d != pbw_pkg::PBW_RECALL);
        end
    end
    assign tap_select = tap_q;
    assign wiper_position = nvd_q;
    assign nv_req.save_req = save_q;
    assign nv_req.save_data = nvd_q;
    assign ready = rdy_q;

    // ==================================================================
    // checks
    // R04 exactly one tap
    property p_onehot;
        @(posedge clk) disable iff (srst) ready |-> $onehot(tap_select);
    endproperty
    a_onehot: assert property (p_onehot) else $error("tap not one-hot"); // R04
    // recall load may jump end to end, only steps must not wrap
    property p_sat_hi;
        @(posedge clk) disable iff (srst)
            (st_q != pbw_pkg::PBW_RECALL && pos_q == 5'h1F) |=> pos_q != 5'h00;
    endproperty
    a_sat_hi: assert property (p_sat_hi) else $error("wrap at top"); // R10
    property p_sat_lo;
        @(posedge clk) disable iff (srst)
            (st_q != pbw_pkg::PBW_RECALL && pos_q == 5'h00) |=> pos_q != 5'h1F;
    endproperty
    a_sat_lo: assert property (p_sat_lo) else $error("wrap at bottom"); // R10
    property p_both;
        @(posedge clk) disable iff (srst) (up_act && dn_act) |=> $stable(pos_q);
    endproperty
    a_both: assert property (p_both) else $error("step with both pressed"); // R20
    property p_release;
        @(posedge clk) disable iff (srst)
            (st_q == pbw_pkg::PBW_SLOW && !up_act && !dn_act) |=> st_q == pbw_pkg::PBW_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("no standby on release"); // R09
    property p_lock;
        @(posedge clk) disable iff (srst) lock_q |=> $stable(pos_q);
    endproperty
    a_lock: assert property (p_lock) else $error("moved while locked"); // R15
    property p_manual;
        @(posedge clk) disable iff (srst)
            (st_q != pbw_pkg::PBW_RECALL && ase_hi && !ase_prev_q) |=> nv_req.save_req;
    endproperty
    a_manual: assert property (p_manual) else $error("manual save missing"); // R14
    property p_step1;
        @(posedge clk) disable iff (srst)
            (st_q == pbw_pkg::PBW_IDLE && up_act && !dn_act && !lock_q && pos_q != 5'h1F)
            |=> pos_q == $past(pos_q) + 5'h01;
    endproperty
    a_step1: assert property (p_step1) else $error("up step missing"); // R01
endmodule

// ---- verification/pbw_button_model.sv ----
// stand-in for the push buttons and the nonvolatile store
// assumes the bench sets press levels just after a clock edge
`timescale 1ns/1ps
module pbw_button_model #(
    parameter logic [4:0] INIT = 5'h05
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic up_press,
    input wire logic dn_press,
    input wire logic st_press,
    input wire pbw_pkg::pbw_nv_req_t nv_req,
    output logic step_up_button_n,
    output logic step_down_button_n,
    output logic store_mode_select_n,
    output logic recall_valid,
    output logic [4:0] recall_data
);
    logic [4:0] mem_q = INIT;
    logic [1:0] cnt_q = 2'h0;
    // ==========================================
    // pins: pulled up, low only while pressed
    // store pin pulsed low then high
    assign step_up_button_n = ~up_press;
    assign step_down_button_n = ~dn_press;
    assign store_mode_select_n = ~st_press;
    // ==========================================
    // store: answers once after each reset
    // recall data after reset
    assign recall_valid = (cnt_q == 2'h2);
    // outside the valid cycle the data lines show junk, not the value
    assign recall_data = recall_valid ? mem_q : ~mem_q;
    always @(posedge clk) begin
        cnt_q <= srst ? 2'h0 : ((cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1);
        if (nv_req.save_req === 1'b1) begin
            mem_q <= nv_req.save_data;
        end
    end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the push-button wiper counter
// assumes shortened timing counts; one tick per clock cycle
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic st = 1'b0;
    logic supply_loss = 1'b0;
    logic up_n, dn_n, st_n, rv, ready;
    logic [4:0] rd, pos;
    logic [31:0] tap;
    pbw_pkg::pbw_nv_req_t nv_req;
    int n_mismatch = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    pbw_button_model mdl (.clk(clk), .srst(srst), .up_press(up), .dn_press(dn),
        .st_press(st), .nv_req(nv_req), .step_up_button_n(up_n),
        .step_down_button_n(dn_n), .store_mode_select_n(st_n),
        .recall_valid(rv), .recall_data(rd));
    pbw_top #(.DEBOUNCE_TICKS(4), .SLOW_TICKS(10), .FAST_TICKS(3), .LONG_TICKS(30),
        .TICK_CYC(1)) dut (.clk(clk), .srst(srst),
        .step_up_button_n(up_n), .step_down_button_n(dn_n),
        .store_mode_select_n(st_n), .supply_loss(supply_loss), .recall_valid(rv),
        .recall_data(rd), .tap_select(tap), .wiper_position(pos), .nv_req(nv_req),
        .ready(ready));
    // ==========================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic pos_is(input logic [4:0] e);
        chk("wiper_position", {27'h000_0000, e}, {27'h000_0000, pos});
        chk("tap_select", 32'h0000_0001 << e, tap);
    endtask
    task automatic do_reset(input logic s);
        srst = 1'b1;
        st = s;
        cyc(10);
        srst = 1'b0;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) cyc(1);
        chk("ready", 32'h0000_0001, {31'h0000_0000, ready});
        if (ready !== 1'b1) end_sim();
        // wiper_position trails ready by one cycle
        cyc(1);
    endtask
    task automatic wait_save(input logic [4:0] e);
        for (int i = 0; i < 40 && nv_req.save_req !== 1'b1; i++) cyc(1);
        chk("save_req", 32'h0000_0001, {31'h0000_0000, nv_req.save_req});
        if (nv_req.save_req !== 1'b1) end_sim();
        chk("save_data", {27'h000_0000, e}, {27'h000_0000, nv_req.save_data});
    endtask
    task automatic press(input logic u, input logic d, input int n, input logic [4:0] e);
        up = u;
        dn = d;
        cyc(n);
        up = 1'b0;
        dn = 1'b0;
        cyc(30);
        pos_is(e);
    endtask
    // held press: spacing of changes early and late, then the end stop
    task automatic s_scan(input logic u, input logic [4:0] e);
        int last = -1;
        int g_slow = 0;
        int g_fast = 0;
        logic [4:0] p = pos;
        up = u;
        dn = ~u;
        for (int c = 0; c < 250; c++) begin
            cyc(1);
            if (pos !== p) begin
                if (last >= 0 && g_slow == 0) g_slow = c - last;
                if (last >= 0) g_fast = c - last;
                last = c;
                p = pos;
            end
        end
        up = 1'b0;
        dn = 1'b0;
        chk("slow_gap", 32'h0000_0001, {31'h0, g_slow >= 4 && g_slow <= 15});
        chk("fast_gap", 32'h0000_0001, {31'h0, g_fast >= 1 && g_fast <= 4});
        pos_is(e);
    endtask
    // ==========================================
    // main sequence
    initial begin
        do_reset(1'b0);
        pos_is(5'h05);
        press(1'b1, 1'b0, 2, 5'h05);
        press(1'b1, 1'b0, 8, 5'h06);
        press(1'b0, 1'b1, 8, 5'h05);
        press(1'b1, 1'b1, 60, 5'h05);
        s_scan(1'b1, 5'h1f);
        st = 1'b1;
        cyc(10);
        press(1'b0, 1'b1, 40, 5'h1f);
        st = 1'b0;
        wait_save(5'h1f);
        cyc(20);
        s_scan(1'b0, 5'h00);
        do_reset(1'b1);
        pos_is(5'h1f);
        press(1'b0, 1'b1, 8, 5'h1e);
        supply_loss = 1'b1;
        wait_save(5'h1e);
        supply_loss = 1'b0;
        end_sim();
    end
endmodule
